// file: verilog/asrs_top.sv
`include "asrs_consts.svh"
module asrs_top #(
    parameter int ADDR_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [3:0] watch_rate_select,
    output logic [2:0] standby_rate_select,
    output logic [2:0] power_mode,
    output logic [15:0] watch_rate_dhz,
    output logic [15:0] standby_rate_dhz,
    output logic watch_rate_ok,
    output logic standby_rate_ok,
    output logic rate_applicable,
    output logic custom_rate_sel
);
    // ============================================================
    // Elaboration checks
    // ============================================================
    // The own registers sit at 0x48 and 0x80..0x88, so eight bits are the floor
    if (ADDR_W < 8) begin : g_bad_addr
        $error("asrs_top: ADDR_W must be at least 8");
    end

    // ============================================================
    // Declarations
    // ============================================================
    localparam logic [7:0] CTRL_ADDR = 8'(`ASRS_CTRL_IDX * 4); // Word index to byte address

    asrs_rate_if rif ();
    logic [7:0] ctrl_r; // Rate control register
    logic [7:0] ctrl_nxt;
    logic [2:0] pm_r; // Power mode context
    logic [2:0] pm_nxt;
    logic [7:0] trig_r; // Trigger count context
    logic [7:0] trig_nxt;
    logic [31:0] rdata_r; // Read data, latched at setup
    logic [31:0] rdata_nxt;
    logic err_r; // Unmapped access flag
    logic err_nxt;
    logic [15:0] wdhz_r; // Registered watch rate
    logic [15:0] sdhz_r; // Registered standby rate
    logic wok_r; // Watch code supported
    logic sok_r; // Standby code supported
    logic mok_r; // Power mode recognised
    logic appl_r; // Trigger count above one
    logic [15:0] wdhz_nxt;
    logic [15:0] sdhz_nxt;
    logic wok_nxt;
    logic sok_nxt;
    logic mok_nxt;
    logic appl_nxt;
    logic setup_ph; // APB setup cycle
    logic access_ph; // APB access cycle
    logic [7:0] addr8; // Low address byte
    logic hit_ctrl;
    logic hit_ctx;
    logic hit_rate;
    logic hit_stat;

    // ============================================================
    // Address decode
    // ============================================================
    // Upper address bits must be zero for a hit
    assign addr8 = paddr[7:0];
    assign setup_ph = psel & ~penable;
    assign access_ph = psel & penable;
    always_comb begin
        hit_ctrl = 1'b0;
        hit_ctx = 1'b0;
        hit_rate = 1'b0;
        hit_stat = 1'b0;
        if (paddr >> 8 == '0) begin
            hit_ctrl = (addr8 == CTRL_ADDR);
            hit_ctx = (addr8 == `ASRS_CTX_ADDR);
            hit_rate = (addr8 == `ASRS_RATE_ADDR);
            hit_stat = (addr8 == `ASRS_STAT_ADDR);
        end
    end

    // ============================================================
    // Rate lookup
    // ============================================================
    assign rif.power_mode = pm_r;
    assign rif.watch_code = ctrl_r[`ASRS_WATCH_MSB:`ASRS_WATCH_LSB];
    assign rif.standby_code = ctrl_r[`ASRS_STB_MSB:`ASRS_STB_LSB];

    asrs_rate_lut u_lut (
        .rif(rif)
    );

    // ============================================================
    // Register file next state
    // ============================================================
    // Writes land at the access edge; reads are latched one cycle
    // earlier in setup so prdata comes straight from a flop.
    always_comb begin
        ctrl_nxt = ctrl_r;
        pm_nxt = pm_r;
        trig_nxt = trig_r;
        rdata_nxt = rdata_r;
        err_nxt = err_r;
        if (access_ph && pwrite && hit_ctrl) begin
            // Bit 4 is held at zero even if software slips
            ctrl_nxt = pwdata[7:0] & ~(8'h01 << `ASRS_ZERO_BIT);
        end
        if (access_ph && pwrite && hit_ctx) begin
            pm_nxt = pwdata[`ASRS_PM_MSB:0];
            trig_nxt = pwdata[`ASRS_TRIG_MSB:`ASRS_TRIG_LSB];
        end
        if (setup_ph) begin
            err_nxt = ~(hit_ctrl | hit_ctx | hit_rate | hit_stat);
            rdata_nxt = 32'h0000_0000;
            if (hit_ctrl) begin
                rdata_nxt = {24'h00_0000, ctrl_r};
            end
            if (hit_ctx) begin
                rdata_nxt = {16'h0000, trig_r, 5'h00, pm_r};
            end
            if (hit_rate) begin
                rdata_nxt = {sdhz_r, wdhz_r};
            end
            if (hit_stat) begin
                rdata_nxt = {27'h000_0000, custom_rate_sel, mok_r, appl_r, sok_r, wok_r};
            end
        end
    end

    // ============================================================
    // Rate status next state
    // ============================================================
    // One flop stage between lookup and outputs keeps them glitch free
    always_comb begin
        wdhz_nxt = rif.watch_dhz;
        sdhz_nxt = rif.standby_dhz;
        wok_nxt = rif.watch_ok & rif.mode_ok;
        sok_nxt = rif.standby_ok & rif.mode_ok;
        mok_nxt = rif.mode_ok;
        // Table figures only describe multi-sample triggering
        appl_nxt = (trig_r > `ASRS_TRIG_MIN);
    end

    // ============================================================
    // State registers
    // ============================================================
    // All cleared at reset so both rate fields start at code zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `ASRS_CTRL_RST;
            pm_r <= `ASRS_PM_RST;
            trig_r <= `ASRS_TRIG_RST;
            rdata_r <= 32'h0000_0000;
            err_r <= 1'b0;
            wdhz_r <= 16'h0000;
            sdhz_r <= 16'h0000;
            wok_r <= 1'b0;
            sok_r <= 1'b0;
            mok_r <= 1'b0;
            appl_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            pm_r <= pm_nxt;
            trig_r <= trig_nxt;
            rdata_r <= rdata_nxt;
            err_r <= err_nxt;
            wdhz_r <= wdhz_nxt;
            sdhz_r <= sdhz_nxt;
            wok_r <= wok_nxt;
            sok_r <= sok_nxt;
            mok_r <= mok_nxt;
            appl_r <= appl_nxt;
        end
    end

    // ============================================================
    // Outputs
    // ============================================================
    // Zero wait states: every access phase completes at once
    assign pready = 1'b1;
    assign pslverr = access_ph & err_r;
    assign prdata = rdata_r;
    assign watch_rate_select = ctrl_r[`ASRS_WATCH_MSB:`ASRS_WATCH_LSB];
    assign standby_rate_select = ctrl_r[`ASRS_STB_MSB:`ASRS_STB_LSB];
    assign power_mode = pm_r;
    assign watch_rate_dhz = wdhz_r;
    assign standby_rate_dhz = sdhz_r;
    assign watch_rate_ok = wok_r;
    assign standby_rate_ok = sok_r;
    assign rate_applicable = appl_r;
    // Custom code only flagged; shadow setup is software's job
    assign custom_rate_sel = (watch_rate_select == `ASRS_CUSTOM_CODE);

    // ============================================================
    // Assertions
    // ============================================================
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    ctrl_write_a: assert property ((access_ph && pwrite && hit_ctrl) |=>
        (watch_rate_select == $past(pwdata[3:0])) && (standby_rate_select == $past(pwdata[7:5])))
        else $error("rate control write not stored");

    stb_fastest_a: assert property ((standby_rate_select == 3'h7 && power_mode == 3'h0) |=>
        ##1 (standby_rate_dhz == 16'h03E8 || $past(standby_rate_select) != 3'h7 || $past(power_mode) != 3'h0))
        else $error("standby top code rate wrong");

    stb_lowest_a: assert property ((standby_rate_select == 3'h0 && power_mode == 3'h4) [*2] |->
        standby_rate_dhz == 16'h0001)
        else $error("standby code zero rate wrong");

    mode_scale_a: assert property ((watch_rate_select == 4'h1 && power_mode == 3'h4) [*2] |->
        watch_rate_dhz == 16'h0002)
        else $error("precision watch rate not scaled");

    bad_mode_a: assert property ((!(power_mode inside {3'h0, 3'h3, 3'h4})) [*2] |->
        !watch_rate_ok && !standby_rate_ok)
        else $error("unknown power mode reported supported");

    trig_gate_a: assert property (rate_applicable == ($past(trig_r) > 8'h01))
        else $error("applicability flag mismatch");

    bit4_read_a: assert property ((setup_ph && hit_ctrl) |=> prdata[31:4] == {24'h00_0000, ctrl_r[7:5], 1'b0})
        else $error("control read shows reserved bit");

    na_code_a: assert property ((watch_rate_select == 4'hD) [*2] |-> !watch_rate_ok)
        else $error("n/a watch code reported supported");

    ctrl_wr_c: cover property (access_ph && pwrite && hit_ctrl);
    custom_c: cover property (custom_rate_sel && watch_rate_ok);
    unmapped_c: cover property (pslverr);
    appl_c: cover property (rate_applicable && standby_rate_ok);
endmodule

// file: common/asrs_consts.svh
`ifndef ASRS_CONSTS_SVH
`define ASRS_CONSTS_SVH

// ============================================================
// Register indices and byte addresses
// ============================================================
`define ASRS_CTRL_IDX 8'h12
`define ASRS_CTX_ADDR 8'h80
`define ASRS_RATE_ADDR 8'h84
`define ASRS_STAT_ADDR 8'h88

// ============================================================
// Field positions
// ============================================================
`define ASRS_WATCH_LSB 0
`define ASRS_WATCH_MSB 3
`define ASRS_ZERO_BIT 4
`define ASRS_STB_LSB 5
`define ASRS_STB_MSB 7
`define ASRS_PM_MSB 2
`define ASRS_TRIG_LSB 8
`define ASRS_TRIG_MSB 15

// ============================================================
// Reset values and special codes
// ============================================================
`define ASRS_CTRL_RST 8'h00
`define ASRS_PM_RST 3'h0
`define ASRS_TRIG_RST 8'h00
`define ASRS_TRIG_MIN 8'h01
`define ASRS_CUSTOM_CODE 4'hF
`endif

// file: common/asrs_pkg.sv
package asrs_pkg;
    // Power mode encodings of the separate power-mode field
    typedef enum logic [2:0] {
        ASRS_PM_LP = 3'h0,
        ASRS_PM_ULP = 3'h3,
        ASRS_PM_PREC = 3'h4
    } asrs_pmode_t;
    // Rates in tenths of a hertz, zero meaning unavailable
    typedef logic [15:0] asrs_dhz_t;
endpackage

// file: common/asrs_rate_if.sv
// ============================================================
// Codes in, looked-up rates out
// ============================================================
interface asrs_rate_if;
    logic [2:0] power_mode;
    logic [3:0] watch_code;
    logic [2:0] standby_code;
    asrs_pkg::asrs_dhz_t watch_dhz;
    asrs_pkg::asrs_dhz_t standby_dhz;
    logic watch_ok;
    logic standby_ok;
    logic mode_ok;
    modport lut (input power_mode, input watch_code, input standby_code,
                 output watch_dhz, output standby_dhz, output watch_ok, output standby_ok, output mode_ok);
    modport ctl (output power_mode, output watch_code, output standby_code,
                 input watch_dhz, input standby_dhz, input watch_ok, input standby_ok, input mode_ok);
endinterface

// file: verilog/asrs_rate_lut.sv
`include "asrs_consts.svh"
module asrs_rate_lut (
    asrs_rate_if.lut rif
);
    // ============================================================
    // Rate tables, tenths of a hertz, zero is n/a
    // ============================================================
    localparam logic [15:0] W_ULP [16] = '{16'h003C, 16'h0004, 16'h0008, 16'h000F, 16'h003C, 16'h0082,
        16'h00FA, 16'h01F4, 16'h03E8, 16'h076C, 16'h0ED8, 16'h1D4C, 16'h2AF8, 16'h0000, 16'h0000, 16'h32C8};
    localparam logic [15:0] W_LP [16] = '{16'h0046, 16'h0004, 16'h0008, 16'h000F, 16'h0046, 16'h008C,
        16'h0118, 16'h021C, 16'h041A, 16'h0834, 16'h0FA0, 16'h1770, 16'h0000, 16'h0000, 16'h0000, 16'h1D4C};
    localparam logic [15:0] W_PREC [16] = '{16'h0046, 16'h0002, 16'h0004, 16'h0009, 16'h0046, 16'h008C,
        16'h0118, 16'h0226, 16'h0320, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h03E8};
    localparam logic [15:0] S_ULP [8] = '{16'h000A, 16'h001E, 16'h0032, 16'h0064,
        16'h00E6, 16'h01C2, 16'h0384, 16'h0708};
    localparam logic [15:0] S_LP [8] = '{16'h0005, 16'h000A, 16'h001E, 16'h003C,
        16'h0078, 16'h00F0, 16'h01E0, 16'h03E8};
    localparam logic [15:0] S_PREC [8] = '{16'h0001, 16'h0002, 16'h0004, 16'h0008,
        16'h000F, 16'h001E, 16'h0032, 16'h0064};

    // Table choice follows power mode; unknown modes give nothing
    always_comb begin
        rif.mode_ok = 1'b1;
        case (rif.power_mode)
            asrs_pkg::ASRS_PM_ULP: begin
                rif.watch_dhz = W_ULP[rif.watch_code];
                rif.standby_dhz = S_ULP[rif.standby_code];
            end
            asrs_pkg::ASRS_PM_LP: begin
                rif.watch_dhz = W_LP[rif.watch_code];
                rif.standby_dhz = S_LP[rif.standby_code];
            end
            asrs_pkg::ASRS_PM_PREC: begin
                rif.watch_dhz = W_PREC[rif.watch_code];
                rif.standby_dhz = S_PREC[rif.standby_code];
            end
            default: begin
                rif.mode_ok = 1'b0;
                rif.watch_dhz = 16'h0000;
                rif.standby_dhz = 16'h0000;
            end
        endcase
        // Zero entries mark unsupported codes
        rif.watch_ok = (rif.watch_dhz != 16'h0000);
        rif.standby_ok = (rif.standby_dhz != 16'h0000);
    end
endmodule

// file: verif/asrs_apb_host.sv
// ============================================================
// Host software model: APB master issuing register accesses
// ============================================================
module asrs_apb_host (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 1ps;

    // Bus idle from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
    end

    // One transfer: setup, then access held until pready is seen high
    // No wait count is assumed; only the bench timeout ends a hang
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        // Answer taken at the completing edge, before release
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

// file: verif/activity_standby_rate_select_tb.sv
// ============================================================
// Bench for the rate select register block
// ============================================================
module activity_standby_rate_select_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, d;
    logic [3:0] watch_rate_select;
    logic [2:0] standby_rate_select, power_mode;
    logic [15:0] watch_rate_dhz, standby_rate_dhz;
    logic watch_rate_ok, standby_rate_ok, rate_applicable, custom_rate_sel, e;
    int bad_count, checks_done, cyc;

    // Expected rates in tenths of a hertz, rows ultra-low, low, precision
    localparam logic [15:0] WTAB [3][16] = '{
        '{16'h3C, 16'h4, 16'h8, 16'hF, 16'h3C, 16'h82, 16'hFA, 16'h1F4,
          16'h3E8, 16'h76C, 16'hED8, 16'h1D4C, 16'h2AF8, 16'h0, 16'h0, 16'h32C8},
        '{16'h46, 16'h4, 16'h8, 16'hF, 16'h46, 16'h8C, 16'h118, 16'h21C,
          16'h41A, 16'h834, 16'hFA0, 16'h1770, 16'h0, 16'h0, 16'h0, 16'h1D4C},
        '{16'h46, 16'h2, 16'h4, 16'h9, 16'h46, 16'h8C, 16'h118, 16'h226,
          16'h320, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h3E8}};
    localparam logic [15:0] STAB [3][8] = '{
        '{16'hA, 16'h1E, 16'h32, 16'h64, 16'hE6, 16'h1C2, 16'h384, 16'h708},
        '{16'h5, 16'hA, 16'h1E, 16'h3C, 16'h78, 16'hF0, 16'h1E0, 16'h3E8},
        '{16'h1, 16'h2, 16'h4, 16'h8, 16'hF, 16'h1E, 16'h32, 16'h64}};
    localparam logic [2:0] PM [3] = '{asrs_pkg::ASRS_PM_ULP, asrs_pkg::ASRS_PM_LP, asrs_pkg::ASRS_PM_PREC};

    asrs_top #(.ADDR_W(8)) asrs_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .watch_rate_select(watch_rate_select), .standby_rate_select(standby_rate_select),
        .power_mode(power_mode), .watch_rate_dhz(watch_rate_dhz), .standby_rate_dhz(standby_rate_dhz),
        .watch_rate_ok(watch_rate_ok), .standby_rate_ok(standby_rate_ok),
        .rate_applicable(rate_applicable), .custom_rate_sel(custom_rate_sel));

    asrs_apb_host asrs_apb_host_inst (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // ============================================================
    // Clock, timeout and helpers
    // ============================================================
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // Sweep needs under two thousand cycles; ceiling well above
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            wrap_up();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] dummy;
        asrs_apb_host_inst.xfer(1'b1, a, wd, dummy, e);
    endtask

    task automatic rd(input logic [7:0] a);
        asrs_apb_host_inst.xfer(1'b0, a, 32'h00000000, d, e);
    endtask

    task automatic wrap_up();
        $display("Checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ============================================================
    // Main sequence
    // ============================================================
    initial begin
        presetn = 1'b0;
        bad_count = 0;
        checks_done = 0;
        cyc = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        // Reset state and low power code zero rates
        rd(8'h48); chk(d, 32'h00000000);
        chk({watch_rate_select, standby_rate_select, power_mode}, 32'h00000000);
        rd(8'h84); chk(d, {16'h0005, 16'h0046});
        // Every code in all three defined modes; bit 4 kept zero by software
        // Custom code is only looked up, its shadow setup is not relied on
        for (int m = 0; m < 3; m++) begin
            for (int c = 0; c < 16; c++) begin
                wr(8'h80, {16'h0000, 8'h02, 5'h00, PM[m]});
                wr(8'h48, {24'h000000, c[2:0], 1'b0, c[3:0]});
                rd(8'h84); chk(d, {STAB[m][c[2:0]], WTAB[m][c]});
                chk({watch_rate_select, standby_rate_select, power_mode}, {c[3:0], c[2:0], PM[m]});
                chk({standby_rate_dhz, watch_rate_dhz}, {STAB[m][c[2:0]], WTAB[m][c]});
                rd(8'h88); chk(d, {27'h0, c == 15, 3'b111, WTAB[m][c] != 0});
                chk(watch_rate_ok, WTAB[m][c] != 0);
                chk({pready, standby_rate_ok}, 32'h00000003);
            end
        end
        // Trigger count boundary around one
        for (int t = 0; t < 4; t++) begin
            wr(8'h80, {16'h0000, 8'(t), 8'h00});
            rd(8'h88); chk(d[2], t > 1);
            chk(rate_applicable, t > 1);
        end
        wr(8'h80, {16'h0000, 8'hFF, 8'h00});
        rd(8'h88); chk(d[2], 1'b1);
        // Deliberate one in bit 4 is stored as zero
        wr(8'h48, 32'h000000FF);
        rd(8'h48); chk(d, 32'h000000EF);
        chk(custom_rate_sel, 1'b1);
        // Undefined power mode gives no rate
        wr(8'h80, 32'h00000001);
        rd(8'h84); chk(d, 32'h00000000);
        rd(8'h88); chk(d, 32'h00000010);
        chk({watch_rate_ok, standby_rate_ok}, 32'h00000000);
        // Unmapped and read-only places
        rd(8'h4C); chk(d, 32'h00000000);
        chk(e, 1'b1);
        wr(8'h4C, 32'h00000012); chk(e, 1'b1);
        wr(8'h84, 32'hFFFFFFFF); chk(e, 1'b0);
        rd(8'h84); chk(d, 32'h00000000);
        rd(8'h48); chk(d, 32'h000000EF);
        // Second reset mid-run clears the register
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h48); chk(d, 32'h00000000);
        rd(8'h80); chk(d, 32'h00000000);
        wrap_up();
    end
endmodule
